// file: core/cbl_step_ctrl.sv
// Purpose: Capacitor step sequencer with LED status frame generation
// Assumes: Measurement inputs come from logic on clk_i; link on link_clk_i
// Notes:   One output changes per tick; LED frame refreshed each tick
`default_nettype none

module cbl_step_ctrl
	import cbl_pkg::*;
#(
	parameter int unsigned TICK_LEN = TICK_CYCLES // Cycles per tick
) (
	input  wire logic              clk_i,              // System clock
	input  wire logic              arst_n_i,           // Async reset, active low
	input  wire logic              link_clk_i,         // LED link clock
	input  wire logic [MEAS_W-1:0] r_var_i,            // R phase reactive power, VAR
	input  wire logic [MEAS_W-1:0] volt_i,             // Measured voltage, V
	input  wire logic [TEMP_W-1:0] temp_i,             // Remote temperature, C
	input  wire logic [MEAS_W-1:0] lux_i,              // Ambient light, lux
	input  wire logic              pf_lead_i,          // Power factor leading
	input  wire logic              pf_lag_i,           // Power factor lagging
	input  wire logic              show_pf_i,          // Display shows power factor
	input  wire logic              show_volt_i,        // Display shows voltage
	input  wire logic              show_curr_i,        // Display shows current
	input  wire logic              phase_r_i,          // Display shows R phase
	input  wire logic              phase_y_i,          // Display shows Y phase
	input  wire logic              phase_b_i,          // Display shows B phase
	output logic                   relay_step_one_o,   // Relay, step one
	output logic                   relay_step_two_o,   // Relay, step two
	output logic                   relay_step_three_o, // Relay, step three
	output logic                   transistor_step_four_o, // Transistor, step four
	output logic                   transistor_step_five_o, // Transistor, step five
	output logic                   driver_reset_line_o,    // Output driver reset
	output logic                   driver_enable_n_line_o, // Output driver enable, low
	output logic                   bright_high_o,      // Display at high current
	output logic                   tick_o,             // One-cycle tick pulse
	output logic                   shift_clk_o,        // Shift clock to LED driver
	output logic                   serial_in_pin_o,    // Data to LED driver
	output logic                   latch_strobe_o,     // LED driver latch
	output logic                   drive_gate_n_o      // LED driver gate, active low
);

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	// Number of 200 VAR thresholds strictly exceeded, capped at five
	function automatic logic [CNT_W-1:0] steps_wanted(input logic [MEAS_W-1:0] pwr);
		logic [CNT_W-1:0] n;
		n = CNT_ZERO;
		for (int i = 1; i <= NSTEP; i++) begin
			if ({16'h0000, pwr} > (32'(i) * {16'h0000, STEP_VAR})) begin
				n = CNT_W'(i);
			end
		end
		return n;
	endfunction

	// Thermometer code: bit k set when count exceeds k
	function automatic logic [NSTEP-1:0] thermo(input logic [CNT_W-1:0] n);
		logic [NSTEP-1:0] t;
		t = '0;
		for (int k = 0; k < NSTEP; k++) begin
			t[k] = (n > CNT_W'(k));
		end
		return t;
	endfunction

	// Overvoltage limit, 110 percent of nominal; exact for 230 V
	localparam logic [31:0] OV_LIMIT =
		({16'h0000, NOMINAL_VOLT} * {16'h0000, OV_PERCENT}) / {16'h0000, PERCENT_DIV};

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	logic [31:0]       tick_cnt;     // Cycles into current tick
	logic              tick;         // Tick pulse
	cbl_state_e        state;        // Control state
	logic [MEAS_W-1:0] var_s;        // Sampled reactive power
	logic [MEAS_W-1:0] volt_s;       // Sampled voltage
	logic [TEMP_W-1:0] temp_s;       // Sampled temperature
	logic [MEAS_W-1:0] lux_s;        // Sampled light level
	logic [7:0]        param_s;      // Sampled display parameter flags
	logic [CNT_W-1:0]  present;      // Steps switched in
	logic [CNT_W-1:0]  desired;      // Steps asked for
	logic [NSTEP-1:0]  outs;         // Output drive, step one at bit 0
	logic [NSTEP-1:0]  lamps;        // Step lamps, step one at bit 0
	logic              lamp_overvoltage; // Overvoltage lamp
	logic              lamp_overtemp;    // Overtemperature lamp
	logic              lamp_low_light;   // Low light lamp
	logic [FRAME_W-1:0] frame;       // Frame handed to the link
	logic              req_tgl;      // Frame request toggle
	logic              done_tgl;     // Completion toggle, link domain
	logic              done_meta;    // First sync stage
	logic              done_sync;    // Second sync stage
	logic              link_busy;    // Frame still in flight

	// ------------------------------------------------------------------
	// Tick generator
	// ------------------------------------------------------------------
	// Free-running period counter; tick lasts one cycle
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			tick_cnt <= '0;
		end else if (tick_cnt == TICK_LEN - 32'd1) begin
			tick_cnt <= '0;
		end else begin
			tick_cnt <= tick_cnt + 32'd1;
		end
	end

	assign tick   = (tick_cnt == TICK_LEN - 32'd1);
	assign tick_o = tick;

	// ------------------------------------------------------------------
	// Control sequence
	// ------------------------------------------------------------------
	// A tick seen while a frame is still in flight is skipped; with a
	// 16-bit frame on a fast link that cannot happen at real tick lengths
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state <= ST_IDLE;
		end else begin
			case (state)
				ST_IDLE: begin
					if (tick) begin
						state <= ST_STEP;
					end
				end
				ST_STEP: begin
					state <= ST_LOAD;
				end
				ST_LOAD: begin
					state <= ST_WAIT;
				end
				ST_WAIT: begin
					if (!link_busy) begin
						state <= ST_IDLE;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Measurement sampling
	// ------------------------------------------------------------------
	// All comparisons of one tick see the same snapshot
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			var_s   <= '0;
			volt_s  <= '0;
			temp_s  <= '0;
			lux_s   <= '0;
			param_s <= '0;
		end else if (state == ST_IDLE && tick) begin
			var_s   <= r_var_i; // R phase only
			volt_s  <= volt_i;
			temp_s  <= temp_i;
			lux_s   <= lux_i;   // Once per tick
			param_s <= {pf_lead_i, pf_lag_i, show_pf_i, show_volt_i,
			            show_curr_i, phase_r_i, phase_y_i, phase_b_i};
		end
	end

	assign desired = steps_wanted(var_s);

	// ------------------------------------------------------------------
	// Step sequencing
	// ------------------------------------------------------------------
	// One step per tick toward the target, so switch-on runs one to five
	// and switch-off five to one, a tick apart; drives are registered so
	// the relay lines never see a decode glitch
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			present <= CNT_ZERO;
			outs    <= '0;
		end else if (state == ST_STEP) begin
			if (present < desired) begin
				present <= present + CNT_ONE;
				outs    <= thermo(present + CNT_ONE);
			end else if (present > desired) begin
				present <= present - CNT_ONE;
				outs    <= thermo(present - CNT_ONE);
			end
		end
	end

	// Step lamps follow outputs only with enough line voltage
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			lamps <= '0;
		end else if (state == ST_LOAD && volt_s > MIN_VOLT) begin
			lamps <= outs; // Paired with outputs
		end
	end

	// Alarm lamps and brightness from the tick's snapshot
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			lamp_overvoltage <= 1'b0;
			lamp_overtemp    <= 1'b0;
			lamp_low_light   <= 1'b0;
			bright_high_o    <= 1'b0;
		end else if (state == ST_STEP) begin
			lamp_overvoltage <= ({16'h0000, volt_s} > OV_LIMIT);
			lamp_overtemp    <= (temp_s > TEMP_LIMIT);
			lamp_low_light   <= (lux_s < LUX_LIMIT);
			bright_high_o    <= (lux_s >= LUX_LIMIT);
		end
	end

	// ------------------------------------------------------------------
	// Outputs to relay and transistor stage
	// ------------------------------------------------------------------
	// Exactly five drives; all low from reset since outs resets to zero
	assign relay_step_one_o       = outs[0];
	assign relay_step_two_o       = outs[1];
	assign relay_step_three_o     = outs[2];
	assign transistor_step_four_o = outs[3];
	assign transistor_step_five_o = outs[4];

	// Driver control lines stay at their reset level throughout
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			driver_reset_line_o    <= 1'b0;
			driver_enable_n_line_o <= 1'b0;
		end else begin
			driver_reset_line_o    <= 1'b0;
			driver_enable_n_line_o <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// Frame build and hand-off
	// ------------------------------------------------------------------
	// Frame is rebuilt only while the link is idle, so the link can read
	// it directly after its toggle synchroniser without a second copy
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			frame   <= '0;
			req_tgl <= 1'b0;
		end else if (state == ST_LOAD) begin
			frame[LB_STEP1] <= (volt_s > MIN_VOLT) ? outs[0] : lamps[0];
			frame[LB_STEP2] <= (volt_s > MIN_VOLT) ? outs[1] : lamps[1];
			frame[LB_STEP3] <= (volt_s > MIN_VOLT) ? outs[2] : lamps[2];
			frame[LB_STEP4] <= (volt_s > MIN_VOLT) ? outs[3] : lamps[3];
			frame[LB_STEP5] <= (volt_s > MIN_VOLT) ? outs[4] : lamps[4];
			frame[LB_OVOLT] <= lamp_overvoltage;
			frame[LB_OTEMP] <= lamp_overtemp;
			frame[LB_LOWLX] <= lamp_low_light;
			frame[LB_LEAD]  <= param_s[7];
			frame[LB_LAG]   <= param_s[6];
			frame[LB_PF]    <= param_s[5];
			frame[LB_VOLT]  <= param_s[4];
			frame[LB_CURR]  <= param_s[3];
			frame[LB_PH_R]  <= param_s[2];
			frame[LB_PH_Y]  <= param_s[1];
			frame[LB_PH_B]  <= param_s[0];
			req_tgl         <= ~req_tgl; // Once per tick
		end
	end

	// Completion toggle back from the link domain
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			done_meta <= 1'b0;
			done_sync <= 1'b0;
		end else begin
			done_meta <= done_tgl;
			done_sync <= done_meta;
		end
	end

	assign link_busy = (req_tgl != done_sync);

	// ------------------------------------------------------------------
	// LED link
	// ------------------------------------------------------------------
	// Relies on the sink driver shifting and latching as a plain shift
	// register with latch and gate
	cbl_led_link u_link (
		.link_clk_i      (link_clk_i),
		.arst_n_i        (arst_n_i),
		.req_tgl_i       (req_tgl),
		.frame_i         (frame),
		.done_tgl_o      (done_tgl),
		.shift_clk_o     (shift_clk_o),
		.serial_in_pin_o (serial_in_pin_o),
		.latch_strobe_o  (latch_strobe_o),
		.drive_gate_n_o  (drive_gate_n_o)
	);

endmodule // cbl_step_ctrl

`default_nettype wire

// file: core/cbl_pkg.sv
// Purpose: Shared constants for the capacitor step and LED controller
// Assumes: 125 MHz system clock, integer-unit measurement inputs
// Notes:   Thresholds in VAR, volts, degrees C and lux
`default_nettype none

package cbl_pkg;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int unsigned CLK_HZ       = 125_000_000; // System clock rate
	localparam int unsigned TICK_SECONDS = 4;           // Step and refresh period
	localparam int unsigned TICK_CYCLES  = TICK_SECONDS * CLK_HZ;

	// ------------------------------------------------------------------
	// Measurement widths and thresholds
	// ------------------------------------------------------------------
	localparam int          MEAS_W       = 16;          // Power, voltage, lux width
	localparam int          TEMP_W       = 8;           // Temperature width
	localparam int          NSTEP        = 5;           // Three relays plus two transistors
	localparam int          CNT_W        = 3;           // Width of a step count
	localparam logic [15:0] STEP_VAR     = 16'h00c8;    // 200 VAR per step
	localparam logic [15:0] MIN_VOLT     = 16'h0017;    // 23 V lamp update floor
	localparam logic [15:0] NOMINAL_VOLT = 16'h00e6;    // 230 V nominal line voltage
	localparam logic [15:0] OV_PERCENT   = 16'h006e;    // 110 percent
	localparam logic [15:0] PERCENT_DIV  = 16'h0064;    // Percent divisor
	localparam logic [7:0]  TEMP_LIMIT   = 8'h32;       // 50 degrees C
	localparam logic [15:0] LUX_LIMIT    = 16'h0064;    // 100 lux
	localparam logic [2:0]  CNT_ZERO     = 3'h0;        // Empty step count
	localparam logic [2:0]  CNT_ONE      = 3'h1;        // One step

	// ------------------------------------------------------------------
	// LED frame bit positions (first byte shifted: LED one at bit 15)
	// ------------------------------------------------------------------
	localparam int LB_STEP5 = 15; // LED 1
	localparam int LB_OVOLT = 14; // LED 2
	localparam int LB_OTEMP = 13; // LED 3
	localparam int LB_STEP4 = 12; // LED 4
	localparam int LB_STEP3 = 11; // LED 5
	localparam int LB_LOWLX = 10; // LED 6
	localparam int LB_LEAD  = 9;  // LED 7
	localparam int LB_STEP2 = 8;  // LED 8
	localparam int LB_STEP1 = 7;  // LED 9
	localparam int LB_LAG   = 6;  // LED 10
	localparam int LB_PF    = 5;  // LED 11
	localparam int LB_PH_R  = 4;  // LED 12
	localparam int LB_PH_Y  = 3;  // LED 13
	localparam int LB_VOLT  = 2;  // LED 14
	localparam int LB_CURR  = 1;  // LED 15
	localparam int LB_PH_B  = 0;  // LED 16
	localparam int FRAME_W  = 16; // Two bytes per update

	// ------------------------------------------------------------------
	// Link sequencing
	// ------------------------------------------------------------------
	localparam logic [3:0] LAST_BIT = 4'hf; // Index of final shifted bit

	// Main control states, one-hot
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_STEP = 4'b0010,
		ST_LOAD = 4'b0100,
		ST_WAIT = 4'b1000
	} cbl_state_e;

	// Link states, one-hot
	typedef enum logic [3:0] {
		LK_IDLE  = 4'b0001,
		LK_SHIFT = 4'b0010,
		LK_LATCH = 4'b0100,
		LK_GATE  = 4'b1000
	} cbl_link_e;

endpackage

`default_nettype wire

// file: core/cbl_led_link.sv
// Purpose: Shifts one 16-bit LED frame to the sink driver, then latches
// Assumes: link_clk_i runs freely; frame_i is held while a request is open
// Notes:   Request and completion cross as toggles
`default_nettype none

module cbl_led_link
	import cbl_pkg::*;
(
	input  wire logic               link_clk_i,   // Link clock
	input  wire logic               arst_n_i,     // Async reset, active low
	input  wire logic               req_tgl_i,    // Frame request toggle (system clock)
	input  wire logic [FRAME_W-1:0] frame_i,      // Frame, stable while requested
	output logic                    done_tgl_o,   // Completion toggle (link clock)
	output logic                    shift_clk_o,  // Shift clock to driver
	output logic                    serial_in_pin_o, // Data to driver serial input
	output logic                    latch_strobe_o,  // Latch strobe
	output logic                    drive_gate_n_o   // Output enable, active low
);

	// ------------------------------------------------------------------
	// Request synchroniser
	// ------------------------------------------------------------------
	logic            req_meta;  // First stage, read only by req_sync
	logic            req_sync;  // Second stage
	logic            req_seen;  // Last toggle acted on
	cbl_link_e       state;     // Link state
	logic [FRAME_W-1:0] shreg;  // Shift register
	logic [3:0]      bitcnt;    // Bits already shifted

	// Two flops before anything looks at the toggle
	always_ff @(posedge link_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			req_meta <= 1'b0;
			req_sync <= 1'b0;
		end else begin
			req_meta <= req_tgl_i;
			req_sync <= req_meta;
		end
	end

	// ------------------------------------------------------------------
	// Frame sequencer
	// ------------------------------------------------------------------
	// Driver samples on the rising shift clock, so data moves as it falls
	always_ff @(posedge link_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state           <= LK_IDLE;
			req_seen        <= 1'b0;
			shreg           <= '0;
			bitcnt          <= '0;
			shift_clk_o     <= 1'b0;
			serial_in_pin_o <= 1'b0;
			latch_strobe_o  <= 1'b0;
			drive_gate_n_o  <= 1'b1; // Outputs dark until first frame
			done_tgl_o      <= 1'b0;
		end else begin
			case (state)
				LK_IDLE: begin
					if (req_sync != req_seen) begin
						// Frame word is stable: it only changes after done
						req_seen        <= req_sync;
						shreg           <= {frame_i[FRAME_W-2:0], 1'b0};
						serial_in_pin_o <= frame_i[FRAME_W-1]; // LED one first
						bitcnt          <= '0;
						state           <= LK_SHIFT;
					end
				end
				LK_SHIFT: begin
					if (!shift_clk_o) begin
						shift_clk_o <= 1'b1; // Driver takes the bit here
					end else begin
						shift_clk_o <= 1'b0;
						if (bitcnt == LAST_BIT) begin
							state <= LK_LATCH;
						end else begin
							serial_in_pin_o <= shreg[FRAME_W-1];
							shreg           <= {shreg[FRAME_W-2:0], 1'b0};
							bitcnt          <= bitcnt + 4'h1;
						end
					end
				end
				LK_LATCH: begin
					latch_strobe_o <= 1'b1; // High after both bytes
					state          <= LK_GATE;
				end
				LK_GATE: begin
					latch_strobe_o <= 1'b0; // Then low
					drive_gate_n_o <= 1'b0; // Then enable sinks
					done_tgl_o     <= ~done_tgl_o;
					state          <= LK_IDLE;
				end
				default: begin
					state <= LK_IDLE;
				end
			endcase
		end
	end

endmodule // cbl_led_link

`default_nettype wire

// file: bench/cbl_step_ctrl_sva.sv
// Purpose: Assertions on the step outputs and LED link of cbl_step_ctrl
// Assumes: Bound from the bench top file
// Notes:   Link checks run on link_clk_i
`default_nettype none
module cbl_step_ctrl_sva #(
	parameter int unsigned TICK_LEN = 2000 // Cycles per tick
) (
	input wire logic clk_i,                  // System clock
	input wire logic arst_n_i,               // Reset, active low
	input wire logic link_clk_i,             // Link clock
	input wire logic relay_step_one_o,       // Step one
	input wire logic relay_step_two_o,       // Step two
	input wire logic relay_step_three_o,     // Step three
	input wire logic transistor_step_four_o, // Step four
	input wire logic transistor_step_five_o, // Step five
	input wire logic driver_reset_line_o,    // Driver reset
	input wire logic driver_enable_n_line_o, // Driver enable, low
	input wire logic tick_o,                 // Tick pulse
	input wire logic shift_clk_o,            // Shift clock
	input wire logic serial_in_pin_o,        // Shift data
	input wire logic latch_strobe_o,         // Latch strobe
	input wire logic drive_gate_n_o          // Gate, low
);
	timeunit 1ns;
	timeprecision 1ps;
	wire logic [4:0] outs = {transistor_step_five_o, transistor_step_four_o,
		relay_step_three_o, relay_step_two_o, relay_step_one_o}; // Step vector
	int unsigned gap; // Cycles since last tick
	// Own count, so a tick counter off by one shows up
	always_ff @(posedge clk_i or negedge arst_n_i)
		if (!arst_n_i) gap <= 0;
		else gap <= tick_o ? 0 : gap + 1;
	// Latch released and gate opened on one edge
	sequence gate_open;
		!latch_strobe_o && !drive_gate_n_o;
	endsequence
	tick_period_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		tick_o |-> gap == TICK_LEN - 1) else $error("tick spacing wrong");
	one_change_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		$countones(outs ^ $past(outs)) <= 1) else $error("several outputs moved");
	thermo_order_a: assert property (@(posedge clk_i)
		disable iff (!arst_n_i) outs inside {5'h00, 5'h01, 5'h03, 5'h07, 5'h0f, 5'h1f})
		else $error("step order broken");
	step_on_tick_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		outs != $past(outs) |-> $past(tick_o, 2)) else $error("output moved off tick");
	driver_lines_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		!driver_reset_line_o && !driver_enable_n_line_o) else $error("driver line high");
	latch_pulse_a: assert property (@(posedge link_clk_i) disable iff (!arst_n_i)
		$rose(latch_strobe_o) |-> !shift_clk_o ##1 gate_open) else $error("latch pulse wrong");
	gate_stays_a: assert property (@(posedge link_clk_i) disable iff (!arst_n_i)
		!drive_gate_n_o |=> !drive_gate_n_o) else $error("gate closed again");
	data_steady_a: assert property (@(posedge link_clk_i) disable iff (!arst_n_i)
		$rose(shift_clk_o) |-> $stable(serial_in_pin_o)) else $error("data moved at shift");
endmodule // cbl_step_ctrl_sva
`default_nettype wire

// file: bench/cbl_led_sink.sv
// Purpose: Model of the 16-channel serial LED sink driver
// Assumes: Data sampled on rising shift clock, MSB arrives first
// Notes:   Latch is transparent while the strobe is high
`default_nettype none
module cbl_led_sink (
	input  wire logic        shift_clk_i,      // Shift clock
	input  wire logic        serial_in_pin_i,  // Serial data in
	input  wire logic        latch_strobe_i,   // Latch strobe
	input  wire logic        drive_gate_n_i,   // Gate, active low
	output logic             serial_out_pin_o, // Cascade out
	output logic [15:0]      led_o             // Sinks, 1 = lit
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] sreg; // Shift register
	logic [15:0] held; // Output latch
	always_ff @(posedge shift_clk_i) sreg <= {sreg[14:0], serial_in_pin_i};
	assign serial_out_pin_o = sreg[15];
	always_latch if (latch_strobe_i) held <= sreg;
	assign led_o = drive_gate_n_i ? 16'h0000 : held;
endmodule // cbl_led_sink
`default_nettype wire

// file: bench/tb_cbl_step_ctrl.sv
// Purpose: Self-checking bench for cbl_step_ctrl with LED sink model
// Assumes: Short tick of 2000 clocks; frame done within 1000 clocks
// Notes:   Inputs change at falling clk edges
`default_nettype none
module tb_cbl_step_ctrl;
	import cbl_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int unsigned TL = 2000; // Short tick keeps the run brief
	logic clk_i = 0, arst_n_i = 0, link_clk_i = 0; // Clocks and reset
	logic [15:0] r_var_i = 0, volt_i = 0, lux_i = 0; // Measurements
	logic [7:0] temp_i = 0, ind = 0; // Temperature; {lead,lag,pf,v,i,r,y,b}
	logic [4:0] outs; // Step outputs
	logic dr, de, br, tk, sc, sd, lt, gn; // Single outputs
	logic [15:0] leds; // Lit sinks seen at the driver
	int bad_count = 0, checks = 0, cnt = 0, lcnt = 0; // Counters, model state
	int sp[5] = '{LB_STEP1, LB_STEP2, LB_STEP3, LB_STEP4, LB_STEP5}; // Lamp bits
	int ip[8] = '{LB_LEAD, LB_LAG, LB_PF, LB_VOLT, LB_CURR, LB_PH_R, LB_PH_Y, LB_PH_B};
	always #4 clk_i = ~clk_i;
	// Odd start offset keeps the link clock out of phase with clk_i
	initial begin
		#23;
		forever #80 link_clk_i = ~link_clk_i;
	end
	cbl_step_ctrl #(.TICK_LEN(TL)) i_dut (.clk_i(clk_i), .arst_n_i(arst_n_i),
		.link_clk_i(link_clk_i), .r_var_i(r_var_i), .volt_i(volt_i), .temp_i(temp_i),
		.lux_i(lux_i), .pf_lead_i(ind[7]), .pf_lag_i(ind[6]), .show_pf_i(ind[5]),
		.show_volt_i(ind[4]), .show_curr_i(ind[3]), .phase_r_i(ind[2]),
		.phase_y_i(ind[1]), .phase_b_i(ind[0]), .relay_step_one_o(outs[0]),
		.relay_step_two_o(outs[1]), .relay_step_three_o(outs[2]),
		.transistor_step_four_o(outs[3]), .transistor_step_five_o(outs[4]),
		.driver_reset_line_o(dr), .driver_enable_n_line_o(de), .bright_high_o(br),
		.tick_o(tk), .shift_clk_o(sc), .serial_in_pin_o(sd), .latch_strobe_o(lt),
		.drive_gate_n_o(gn));
	cbl_led_sink i_sink (.shift_clk_i(sc), .serial_in_pin_i(sd), .latch_strobe_i(lt),
		.drive_gate_n_i(gn), .serial_out_pin_o(), .led_o(leds));
	task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic set_in(logic [15:0] r, v, l, logic [7:0] t, i);
		r_var_i = r;
		volt_i = v;
		lux_i = l;
		temp_i = t;
		ind = i;
	endtask
	// Wait one tick, step the model, compare outputs and the sent frame
	task automatic do_tick();
		int n;
		int des;
		logic [15:0] f;
		n = 0;
		des = 0;
		while (tk !== 1'b1 && n < TL) begin
			@(negedge clk_i);
			n++;
		end
		check("tick", 16'(tk), 16'h0001);
		for (int k = 1; k <= 5; k++) if (r_var_i > STEP_VAR * k) des++;
		if (des > cnt) cnt++;
		else if (des < cnt) cnt--;
		if (volt_i > MIN_VOLT) lcnt = cnt;
		repeat (3) @(negedge clk_i);
		check("steps", 16'(outs), 16'((1 << cnt) - 1));
		check("bright", 16'(br), 16'(lux_i >= LUX_LIMIT));
		f = 16'h0000;
		for (int k = 0; k < 5; k++) f[sp[k]] = lcnt > k;
		for (int k = 0; k < 8; k++) f[ip[k]] = ind[7 - k];
		f[LB_OVOLT] = volt_i > 16'h00fd;
		f[LB_OTEMP] = temp_i > TEMP_LIMIT;
		f[LB_LOWLX] = lux_i < LUX_LIMIT;
		repeat (1000) @(negedge clk_i);
		check("frame", leds, f);
	endtask
	// Reset held over several link cycles so both domains settle
	task automatic t_reset();
		repeat (5) @(negedge link_clk_i);
		check("outs", 16'(outs), 16'h0000);
		check("drv", {14'h0, dr, de}, 16'h0000);
		check("link", {14'h0, lt, gn}, 16'h0001);
		@(negedge clk_i);
		arst_n_i = 1;
	endtask
	// Exactly 1000 VAR stops at four steps; 1001 adds the fifth
	task automatic t_ramp_up();
		set_in(16'h03e8, 16'h00e6, 16'h0064, 8'h32, 8'ha5);
		repeat (4) do_tick();
		set_in(16'h03e9, 16'h00fd, 16'h0064, 8'h32, 8'ha5);
		repeat (2) do_tick();
	endtask
	// At 23 V the lamps hold while the outputs step down
	task automatic t_hold();
		set_in(16'h01f4, 16'h0017, 16'h0064, 8'h32, 8'h3c);
		repeat (4) do_tick();
	endtask
	// All alarms raised while stepping to zero
	task automatic t_down();
		set_in(16'h0000, 16'h00fe, 16'h0063, 8'h33, 8'h5a);
		repeat (3) do_tick();
	endtask
	initial begin
		t_reset();
		t_ramp_up();
		t_hold();
		t_down();
		stop_test();
	end
	// Watchdog: thirteen ticks need about 210 us
	initial begin
		#400us;
		bad_count++;
		stop_test();
	end
endmodule // tb_cbl_step_ctrl
bind cbl_step_ctrl cbl_step_ctrl_sva #(.TICK_LEN(TICK_LEN)) i_sva (.clk_i(clk_i),
	.arst_n_i(arst_n_i), .link_clk_i(link_clk_i), .relay_step_one_o(relay_step_one_o),
	.relay_step_two_o(relay_step_two_o), .relay_step_three_o(relay_step_three_o),
	.transistor_step_four_o(transistor_step_four_o), .tick_o(tick_o),
	.transistor_step_five_o(transistor_step_five_o), .shift_clk_o(shift_clk_o),
	.driver_reset_line_o(driver_reset_line_o), .serial_in_pin_o(serial_in_pin_o),
	.driver_enable_n_line_o(driver_enable_n_line_o), .latch_strobe_o(latch_strobe_o),
	.drive_gate_n_o(drive_gate_n_o));
`default_nettype wire
